//--- flash_host_pkg.sv
// package: constants for the byte-wide flash host controller
// assumes: 50 MHz core clock; all users import the whole package
package flash_host_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int WAKE_NS = 50;
  localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_NS = 120;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = 3;
  localparam int SECTOR_LSB = 13;
  localparam int SECTOR_W = 5;
  localparam logic [7:0] LOW_MFR = 8'h00;
  localparam logic [7:0] LOW_DEV = 8'h01;
  localparam logic [7:0] LOW_PROT = 8'h02;
  localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'hAAA;
  localparam logic [7:0] UNLOCK_D1 = 8'hAA;
  localparam logic [7:0] UNLOCK_D2 = 8'h55;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_ID_HV, OP_ID_CMD, OP_RESET_PIN, OP_STANDBY
  } host_op_e;
  // top-boot sector decode from the five upper address bits
  function automatic logic [2:0] sector_of(input logic [4:0] hi);
    logic [2:0] s;
    s = 3'h0;
    if (hi[4:3] == 2'h0) s = 3'h0;
    else if (hi[4:3] == 2'h1) s = 3'h1;
    else if (hi[4:3] == 2'h2) s = 3'h2;
    else if (hi[2] == 1'b0) s = 3'h3;
    else if (hi[1] == 1'b1) s = 3'h6;
    else if (hi[0] == 1'b0) s = 3'h4;
    else s = 3'h5;
    return s;
  endfunction
  function automatic logic odd_parity(input logic [7:0] b);
    return ^b;
  endfunction
endpackage

//--- flash_pin_if.sv
// interface: strobe request between sequencer and pin driver
// assumes: single core clock domain
`timescale 1ns/10ps
interface flash_pin_if;
  logic start;
  logic wr;
  logic [17:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output start, wr, addr, wdata, input done, rdata);
  modport drv (input start, wr, addr, wdata, output done, rdata);
endinterface

//--- flash_pin_cycle.sv
// module: one asynchronous bus cycle on the flash strobes
// assumes: flash reset pin high and awake before start
`timescale 1ns/10ps
module flash_pin_cycle
  import flash_host_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  flash_pin_if.drv bus,
  input wire logic [7:0] i_dq,
  output logic o_chip_sel_n,
  output logic o_out_gate_n,
  output logic o_write_n,
  output logic [17:0] o_addr,
  output logic [7:0] o_dq_out,
  output logic o_dq_oe
);
  typedef enum logic [1:0] {C_IDLE, C_ACT, C_DONE} cyc_e;
  cyc_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic [17:0] a_r, a_nxt;
  logic [7:0] d_r, d_nxt, rd_r, rd_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    a_nxt = a_r;
    d_nxt = d_r;
    rd_nxt = rd_r;
    case (st_r)
      C_IDLE: begin
        if (bus.start) begin
          st_nxt = C_ACT;
          wr_nxt = bus.wr;
          a_nxt = bus.addr;
          d_nxt = bus.wdata;
          cnt_nxt = bus.wr ? 4'(PULSE_CYC) : 4'(ACCESS_CYC + 1);
        end
      end
      C_ACT: begin
        if (cnt_r == 4'h0) begin
          st_nxt = C_DONE;
          if (!wr_r) rd_nxt = i_dq;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      C_DONE: st_nxt = C_IDLE;
      default: st_nxt = C_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= C_IDLE;
      cnt_r <= 4'h0;
      wr_r <= 1'b0;
      a_r <= 18'h00000;
      d_r <= 8'h00;
      rd_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      a_r <= a_nxt;
      d_r <= d_nxt;
      rd_r <= rd_nxt;
    end
  end

  // read: select and gate low, write high; write: gate high, write low until the last active cycle
  assign o_chip_sel_n = (st_r != C_ACT);
  assign o_out_gate_n = !(st_r == C_ACT && !wr_r);
  assign o_write_n = !(st_r == C_ACT && wr_r && cnt_r != 4'h0);
  assign o_dq_oe = (st_r == C_ACT) && wr_r;
  assign o_dq_out = d_r;
  assign o_addr = a_r;
  assign bus.done = (st_r == C_DONE);
  assign bus.rdata = rd_r;

  AST_NO_CONTENTION: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_dq_oe |-> o_out_gate_n) else $error("host drives data while gate low");
  AST_READ_STROBES: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !o_out_gate_n |-> (!o_chip_sel_n && o_write_n)) else $error("read strobes bad");
endmodule // flash_pin_cycle

//--- flash_host_ctrl.sv
// top: host controller that drives a byte-wide flash through its pins
// assumes: i_dq is the resolved data bus, synchronous to i_core_clk
`timescale 1ns/10ps
module flash_host_ctrl
  import flash_host_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [2:0] i_op,
  input wire logic [17:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_dq,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_parity_err,
  output logic [2:0] o_sector_index,
  output logic o_chip_sel_n,
  output logic o_out_gate_n,
  output logic o_write_n,
  output logic o_flash_rst_n,
  output logic o_identify_high_voltage,
  output logic [17:0] o_addr,
  output logic [7:0] o_dq,
  output logic o_dq_oe
);
  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_WAKE, S_CYC, S_WAIT, S_FIN} seq_e;
  seq_e st_r, st_nxt;
  host_op_e op_r, op_nxt;
  logic [2:0] step_r, step_nxt;
  logic [3:0] wake_r, wake_nxt;
  logic [17:0] a_r, a_nxt;
  logic [7:0] d_r, d_nxt, rd_r, rd_nxt;
  logic rst_pin_r, rst_pin_nxt, hv_r, hv_nxt;
  logic done_r, done_nxt, perr_r, perr_nxt;
  logic [2:0] sec_r, sec_nxt;
  logic start_r, start_nxt;
  logic [17:0] ca_r, ca_nxt;
  logic [7:0] cd_r, cd_nxt;
  logic cw_r, cw_nxt;
  logic busy_r, busy_nxt;
  logic p_cs_n, p_og_n, p_we_n, p_oe;
  logic [17:0] p_addr;
  logic [7:0] p_dq;
  flash_pin_if pif ();
  assign pif.start = start_r;
  assign pif.wr = cw_r;
  assign pif.addr = ca_r;
  assign pif.wdata = cd_r;
  flash_pin_cycle u_cyc (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .bus(pif.drv),
    .i_dq(i_dq),
    .o_chip_sel_n(p_cs_n),
    .o_out_gate_n(p_og_n),
    .o_write_n(p_we_n),
    .o_addr(p_addr),
    .o_dq_out(p_dq),
    .o_dq_oe(p_oe)
  );

  // id address: only selector bits and sector bits kept
  function automatic logic [17:0] id_addr(input logic [17:0] a);
    logic [17:0] r;
    r = 18'h00000;
    r[0] = a[0];
    r[1] = a[1];
    r[SECTOR_LSB +: SECTOR_W] = a[SECTOR_LSB +: SECTOR_W];
    return r;
  endfunction
  // command-sequence step to address/data
  function automatic logic [25:0] cmd_step(input logic [2:0] s, input logic [17:0] a);
    logic [25:0] r;
    r = 26'h0000000;
    case (s)
      3'h0: r = {6'h00, UNLOCK_ADDR1, UNLOCK_D1};
      3'h1: r = {6'h00, UNLOCK_ADDR2, UNLOCK_D2};
      3'h2: r = {6'h00, UNLOCK_ADDR1, CMD_AUTOSEL};
      3'h3: r = {id_addr(a), 8'h00};
      default: r = {6'h00, UNLOCK_ADDR1, CMD_RESET};
    endcase
    return r;
  endfunction
  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    step_nxt = step_r;
    wake_nxt = wake_r;
    a_nxt = a_r;
    d_nxt = d_r;
    rd_nxt = rd_r;
    rst_pin_nxt = rst_pin_r;
    hv_nxt = hv_r;
    done_nxt = 1'b0;
    perr_nxt = perr_r;
    sec_nxt = sec_r;
    start_nxt = 1'b0;
    ca_nxt = ca_r;
    cd_nxt = cd_r;
    cw_nxt = cw_r;
    case (st_r)
      S_IDLE: begin
        if (i_req) begin
          op_nxt = host_op_e'(i_op);
          a_nxt = i_addr;
          d_nxt = i_wdata;
          step_nxt = 3'h0;
          sec_nxt = sector_of(i_addr[SECTOR_LSB +: SECTOR_W]);
          case (host_op_e'(i_op))
            OP_RESET_PIN: begin
              rst_pin_nxt = 1'b0;
              st_nxt = S_FIN;
            end
            OP_STANDBY: st_nxt = S_FIN;
            default: begin
              if (!rst_pin_r) begin
                rst_pin_nxt = 1'b1;
                wake_nxt = 4'(WAKE_CYC);
                st_nxt = S_WAKE;
              end else begin
                st_nxt = S_CYC;
              end
            end
          endcase
        end
      end
      S_WAKE: begin
        if (wake_r == 4'h0) st_nxt = S_CYC;
        else wake_nxt = wake_r - 4'h1;
      end
      S_CYC: begin
        start_nxt = 1'b1;
        st_nxt = S_WAIT;
        case (op_r)
          OP_WRITE: begin
            cw_nxt = 1'b1;
            ca_nxt = a_r;
            cd_nxt = d_r;
          end
          OP_ID_HV: begin
            hv_nxt = 1'b1;
            cw_nxt = 1'b0;
            ca_nxt = id_addr(a_r);
          end
          OP_ID_CMD: begin
            cw_nxt = (step_r != 3'h3);
            {ca_nxt, cd_nxt} = cmd_step(step_r, a_r);
          end
          default: begin
            cw_nxt = 1'b0;
            ca_nxt = a_r;
          end
        endcase
      end
      S_WAIT: begin
        if (pif.done) begin
          if (op_r == OP_ID_CMD && step_r != 3'h4) begin
            if (step_r == 3'h3) rd_nxt = pif.rdata;
            step_nxt = step_r + 3'h1;
            st_nxt = S_CYC;
          end else begin
            if (op_r != OP_ID_CMD) rd_nxt = pif.rdata;
            st_nxt = S_FIN;
          end
        end
      end
      S_FIN: begin
        hv_nxt = 1'b0;
        done_nxt = 1'b1;
        if ((op_r == OP_ID_HV || op_r == OP_ID_CMD) && a_r[1] == 1'b0)
          perr_nxt = !odd_parity(rd_r);
        else
          perr_nxt = 1'b0;
        st_nxt = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
    busy_nxt = (st_nxt != S_IDLE);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= S_IDLE;
      busy_r <= 1'b0;
      op_r <= OP_READ;
      step_r <= 3'h0;
      wake_r <= 4'h0;
      a_r <= 18'h00000;
      d_r <= 8'h00;
      rd_r <= 8'h00;
      rst_pin_r <= 1'b0;
      hv_r <= 1'b0;
      done_r <= 1'b0;
      perr_r <= 1'b0;
      sec_r <= 3'h0;
      start_r <= 1'b0;
      ca_r <= 18'h00000;
      cd_r <= 8'h00;
      cw_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      step_r <= step_nxt;
      wake_r <= wake_nxt;
      a_r <= a_nxt;
      d_r <= d_nxt;
      rd_r <= rd_nxt;
      rst_pin_r <= rst_pin_nxt;
      hv_r <= hv_nxt;
      done_r <= done_nxt;
      perr_r <= perr_nxt;
      sec_r <= sec_nxt;
      start_r <= start_nxt;
      ca_r <= ca_nxt;
      cd_r <= cd_nxt;
      cw_r <= cw_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ------------------------------------------------------------
  // pin registers
  // ------------------------------------------------------------
  logic cs_r, og_r, we_r, oe_r;
  logic [17:0] pa_r;
  logic [7:0] pdat_r;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_r <= 1'b1;
      og_r <= 1'b1;
      we_r <= 1'b1;
      oe_r <= 1'b0;
      pa_r <= 18'h00000;
      pdat_r <= 8'h00;
    end else begin
      cs_r <= p_cs_n;
      og_r <= p_og_n;
      we_r <= p_we_n;
      oe_r <= p_oe;
      pa_r <= p_addr;
      pdat_r <= p_dq;
    end
  end

  assign o_chip_sel_n = cs_r;
  assign o_out_gate_n = og_r;
  assign o_write_n = we_r;
  assign o_dq_oe = oe_r;
  assign o_addr = pa_r;
  assign o_dq = pdat_r;
  assign o_flash_rst_n = rst_pin_r;
  assign o_identify_high_voltage = hv_r;
  assign o_busy = busy_r;
  assign o_done = done_r;
  assign o_rdata = rd_r;
  assign o_parity_err = perr_r;
  assign o_sector_index = sec_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_WAKE_BEFORE_CYCLE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(rst_pin_r) |-> !start_r [*3]) else $error("cycle inside wake-up time");
  AST_RESET_QUIET: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !rst_pin_r |-> (!start_r && st_r != S_WAIT)) else $error("strobes while reset low");
  AST_HV_ADDR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (start_r && op_r == OP_ID_HV) |-> (ca_r[12:2] == 11'h000 && !cw_r))
    else $error("id address not masked");
  AST_PARITY: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (st_r == S_FIN && op_r == OP_ID_HV && !a_r[1]) |=> (perr_r == !(^rd_r)))
    else $error("parity flag wrong");
  AST_SECTOR: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (st_r == S_IDLE && i_req) |=> (sec_r == sector_of($past(i_addr[17:13]))))
    else $error("sector decode wrong");
  AST_CMD_ORDER: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (start_r && op_r == OP_ID_CMD && step_r == 3'h3) |-> !cw_r)
    else $error("id read not a read");
  AST_RESET_DONE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (st_r == S_IDLE && i_req && i_op == 3'(OP_RESET_PIN)) |=> ##1 (done_r && !rst_pin_r))
    else $error("reset op slow");
  AST_HV_DROP: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (st_r == S_FIN) |=> !hv_r) else $error("high voltage left on");
  COV_READ: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    done_r && op_r == OP_READ);
  COV_WRITE: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    done_r && op_r == OP_WRITE);
  COV_IDCMD: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    done_r && op_r == OP_ID_CMD);
endmodule // flash_host_ctrl

//--- flash_dev_model.sv
// model: byte-wide flash device answering the host pins
// assumes: the bench resolves the data bus from both enables
`timescale 1ns/10ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MFR_CODE = 8'h07, // arbitrary value, odd parity
  parameter logic [7:0] DEV_CODE = 8'h8C, // arbitrary value, odd parity
  parameter logic [6:0] PROT_MASK = 7'h25,
  parameter int ACC_NS = 100
)
(
  input wire logic i_chip_sel_n,
  input wire logic i_out_gate_n,
  input wire logic i_write_n,
  input wire logic i_rst_n,
  input wire logic i_id_hv,
  input wire logic i_host_oe,
  input wire logic [17:0] i_addr,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_dq_oe,
  output logic [17:0] o_wr_addr,
  output logic [7:0] o_wr_data,
  output logic o_clash
);
  // ----------------------------------------
  // read path and command decode
  // ----------------------------------------
  logic id_cmd_r = 1'b0;
  logic awake_r = 1'b0;
  logic wr_open_r = 1'b0;
  int step_r = 0;
  logic [17:0] lat_a;
  logic [7:0] wd;
  logic [7:0] data_now;
  logic [7:0] data_dly;
  logic rd_en;
  initial o_clash = 1'b0;
  function automatic logic [2:0] sect(input logic [17:0] a);
    if (a[17:16] != 2'h3) return {1'b0, a[17:16]};
    if (!a[15]) return 3'h3;
    if (a[14]) return 3'h6;
    return a[13] ? 3'h5 : 3'h4;
  endfunction
  always @* begin
    if (!(i_id_hv || id_cmd_r)) data_now = i_addr[7:0] ^ i_addr[15:8] ^ {6'h0, i_addr[17:16]};
    else if (!i_addr[1]) data_now = i_addr[0] ? DEV_CODE : MFR_CODE;
    else data_now = {7'h0, PROT_MASK[sect(i_addr)]};
  end
  assign #(ACC_NS) data_dly = data_now;
  assign rd_en = !i_chip_sel_n && !i_out_gate_n && i_write_n && i_rst_n && awake_r;
  assign o_dq_oe = rd_en;
  assign o_dq = rd_en ? data_dly : ~data_dly;
  always @(negedge i_rst_n) begin
    id_cmd_r = 1'b0;
    step_r = 0;
    wr_open_r = 1'b0;
    awake_r = 1'b0;
  end
  always @(posedge i_rst_n) awake_r <= #(WAKE_NS) 1'b1;
  always @(posedge (i_host_oe && rd_en)) o_clash = 1'b1;
  always @(negedge i_write_n or negedge i_chip_sel_n) begin
    // let both strobes and the address settle before latching
    #1;
    if (!i_write_n && !i_chip_sel_n && i_out_gate_n && i_rst_n) begin
      lat_a = i_addr;
      wr_open_r = 1'b1;
    end
  end
  always @* if (wr_open_r && i_host_oe) wd = i_dq;
  always @(posedge i_write_n or posedge i_chip_sel_n) begin
    if (wr_open_r) begin
      wr_open_r = 1'b0;
      o_wr_addr = lat_a;
      o_wr_data = wd;
      id_cmd_r = step_r == 2 && lat_a[11:0] == 12'h555 && wd == 8'h90;
      case (step_r)
        0: step_r = (lat_a[11:0] == 12'h555 && wd == 8'hAA) ? 1 : 0;
        1: step_r = (lat_a[11:0] == 12'hAAA && wd == 8'h55) ? 2 : 0;
        default: step_r = 0;
      endcase
    end
  end
endmodule // flash_dev_model

//--- flash_bus_ops_autoselect_bench.sv
// bench: host controller against the flash device model
// assumes: design package and interface compiled first
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value %s exp %h got %h", nm, exp, got); end end
module flash_bus_ops_autoselect_bench;
  import flash_host_pkg::*;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  localparam logic [6:0] PROT = 7'h25;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_req = 1'b0;
  logic [2:0] i_op = 3'h0;
  logic [17:0] i_addr = 18'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] float_r = 8'h5A;
  logic o_busy, o_done, o_parity_err, cs_n, og_n, we_n, frst_n, hv, o_dq_oe, dev_oe, clash;
  logic [7:0] o_rdata, o_dq, dev_dq, wr_data, dq_bus;
  logic [2:0] o_sector_index;
  logic [17:0] o_addr, wr_addr;
  int n_errors = 0;
  int cmp_count = 0;
  always #10 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) float_r <= ~float_r;
  assign dq_bus = o_dq_oe ? o_dq : (dev_oe ? dev_dq : float_r);
  flash_host_ctrl dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_req(i_req),
    .i_op(i_op), .i_addr(i_addr), .i_wdata(i_wdata), .i_dq(dq_bus), .o_busy(o_busy),
    .o_done(o_done), .o_rdata(o_rdata), .o_parity_err(o_parity_err),
    .o_sector_index(o_sector_index), .o_chip_sel_n(cs_n), .o_out_gate_n(og_n),
    .o_write_n(we_n), .o_flash_rst_n(frst_n), .o_identify_high_voltage(hv),
    .o_addr(o_addr), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
  flash_dev_model #(.PROT_MASK(PROT), .ACC_NS(110)) dev_u (.i_chip_sel_n(cs_n),
    .i_out_gate_n(og_n), .i_write_n(we_n), .i_rst_n(frst_n), .i_id_hv(hv),
    .i_host_oe(o_dq_oe), .i_addr(o_addr), .i_dq(dq_bus), .o_dq(dev_dq), .o_dq_oe(dev_oe),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_clash(clash));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [7:0] arr(input logic [17:0] a);
    return a[7:0] ^ a[15:8] ^ {6'h0, a[17:16]};
  endfunction
  task automatic final_report();
    if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_op(input logic [2:0] op, input logic [17:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge i_core_clk);
    i_req = 1'b1;
    i_op = op;
    i_addr = a;
    i_wdata = d;
    @(negedge i_core_clk);
    i_req = 1'b0;
    while (o_done !== 1'b1 && n < 200) begin
      @(negedge i_core_clk);
      n++;
    end
    `CHK("done", 1'b1, o_done)
    `CHK("idle at done", 1'b0, o_busy)
  endtask
  task automatic t_idle_pins();
    `CHK("reset pin", 1'b0, frst_n)
    `CHK("strobes", 3'h7, {cs_n, og_n, we_n})
    `CHK("host oe", 1'b0, o_dq_oe)
  endtask
  task automatic t_read_sectors();
    logic [17:0] sa [7] = '{18'h0FFFF, 18'h10000, 18'h2FFFF, 18'h30000, 18'h39FFF,
      18'h3A000, 18'h3C000};
    for (int i = 0; i < 7; i++) begin
      do_op(3'h0, sa[i], 8'h00);
      `CHK("read data", arr(sa[i]), o_rdata)
      `CHK("sector", 3'(i), o_sector_index)
      do_op(3'h2, {sa[i][17:13], 13'h0002}, 8'h00);
      `CHK("protect", {7'h0, PROT[i]}, o_rdata)
    end
  endtask
  task automatic t_ids(input logic [2:0] op);
    do_op(op, 18'h2AB80, 8'h00);
    `CHK("maker id", 8'h07, o_rdata)
    `CHK("high voltage off", 1'b0, hv)
    `CHK("parity flag", 1'b0, o_parity_err)
    do_op(op, 18'h2AB81, 8'h00);
    `CHK("device id", 8'h8C, o_rdata)
    `CHK("odd parity", 1'b1, ^o_rdata)
    do_op(3'h0, 18'h00001, 8'h00);
    `CHK("back to array", arr(18'h00001), o_rdata)
  endtask
  task automatic t_write();
    do_op(3'h1, 18'h2A5C3, 8'h3C);
    `CHK("wr addr", 18'h2A5C3, wr_addr)
    `CHK("wr data", 8'h3C, wr_data)
    do_op(3'h0, 18'h2A5C3, 8'h00);
    `CHK("read after bad cmd", arr(18'h2A5C3), o_rdata)
  endtask
  task automatic t_pin_states();
    do_op(3'h4, 18'h00000, 8'h00);
    `CHK("reset pin held", 1'b0, frst_n)
    do_op(3'h0, 18'h1F0F0, 8'h00);
    `CHK("read after wake", arr(18'h1F0F0), o_rdata)
    do_op(3'h5, 18'h00000, 8'h00);
    `CHK("standby pins", 5'h1E, {cs_n, og_n, we_n, frst_n, o_dq_oe})
    do_op(3'h0, 18'h0A0A5, 8'h00);
    `CHK("read from standby", arr(18'h0A0A5), o_rdata)
  endtask
  task automatic t_busy();
    logic [17:0] prev;
    int dones;
    prev = wr_addr;
    dones = 0;
    @(negedge i_core_clk);
    i_req = 1'b1;
    i_op = 3'h0;
    i_addr = 18'h01234;
    @(negedge i_core_clk);
    `CHK("busy", 1'b1, o_busy)
    i_op = 3'h1;
    i_addr = 18'h15555;
    i_wdata = 8'hAA;
    @(negedge i_core_clk);
    i_req = 1'b0;
    repeat (60) begin
      @(negedge i_core_clk);
      if (o_done === 1'b1) dones++;
    end
    `CHK("done count", 1, dones)
    `CHK("no extra write", prev, wr_addr)
    `CHK("busy read", arr(18'h01234), o_rdata)
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    #1_000_000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (8) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    t_idle_pins();
    t_read_sectors();
    t_ids(3'h2);
    t_ids(3'h3);
    t_write();
    t_pin_states();
    t_busy();
    `CHK("bus clash", 1'b0, clash)
    final_report();
  end
endmodule // flash_bus_ops_autoselect_bench
